/* shared/mrp_defs.svh */
// Offsets, field positions, reset values and timing counts of the register port
`ifndef MRP_DEFS_SVH
`define MRP_DEFS_SVH

// ------------------------------------------------------------
// Register addresses (six-bit command address field)
// ------------------------------------------------------------
`define MRP_ADDR_WAVE 6'h01
`define MRP_ADDR_ENERGY 6'h02
`define MRP_ADDR_MODE 6'h09
`define MRP_ADDR_PHASE 6'h10
`define MRP_ADDR_ZXTO 6'h11
`define MRP_ADDR_CKSUM 6'h3E

// ------------------------------------------------------------
// Command byte fields
// ------------------------------------------------------------
`define MRP_CMD_BITS 8
`define MRP_CMD_WRITE_BIT 7
`define MRP_CMD_ADDR_MSB 5

// ------------------------------------------------------------
// Mode register fields and reset values
// ------------------------------------------------------------
`define MRP_MODE_HALT_BIT 4
`define MRP_MODE_RATE_LSB 11
`define MRP_MODE_RESET 16'h0000
`define MRP_PHASE_RESET 6'h0D
`define MRP_ZXTO_RESET 12'hFFF

// ------------------------------------------------------------
// Master clock division counts
// ------------------------------------------------------------
`define MRP_ENERGY_DIV 4
`define MRP_PHASE_DIV 4
`define MRP_WAVE_DIV_MIN 128
`define MRP_ZXTO_MAX 524288
`define MRP_ZXTO_SCALE 128

`endif

/* shared/mrp_pkg.sv */
// Types shared by the metering register port
package mrp_pkg;

  // Serial engine states
  typedef enum logic [1:0] {
    MRP_ST_CMD,
    MRP_ST_WRITE,
    MRP_ST_READ
  } mrp_state_t;

endpackage

/* hdl/mrp_sync.sv */
// Two-stage synchroniser for asynchronous pins
`timescale 1ns/1ps
module mrp_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_core_clk, // Core clock
  input wire logic i_rst, // Synchronous reset
  input wire logic [WIDTH-1:0] i_async, // Pin levels
  output logic [WIDTH-1:0] o_sync // Synchronised levels
);

  logic [WIDTH-1:0] meta_q;

  // ------------------------------------------------------------
  // Elaboration check
  // ------------------------------------------------------------
  if (WIDTH < 1) begin : g_bad_width
    $error("mrp_sync: WIDTH must be at least 1");
  end

  // First stage is read only by the second stage
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      meta_q <= '0;
      o_sync <= '0;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end

endmodule

/* hdl/mrp_rate_gen.sv */
// Master clock derived strobes: sample rate, energy update, phase delay, timeout
`timescale 1ns/1ps
`include "mrp_defs.svh"
module mrp_rate_gen
  import mrp_pkg::*;
#(
  parameter int DIV_W = 10,
  parameter int ZX_W = 20
) (
  input wire logic i_core_clk, // Core clock
  input wire logic i_rst, // Synchronous reset
  input wire logic i_mclk, // Synchronised master clock level
  input wire logic i_zx, // Synchronised zero-crossing level
  input wire logic [1:0] i_rate_sel, // Sample rate select
  input wire logic [5:0] i_phase_delay, // Phase correction delay
  input wire logic [11:0] i_zx_timeout, // Zero-crossing timeout setting
  output logic o_wave_stb, // Waveform sample strobe
  output logic o_energy_stb, // Energy update strobe
  output logic o_phase_stb, // Delayed sample strobe
  output logic o_zx_expired // Timeout flag, level
);

  logic mclk_prev_q;
  logic zx_prev_q;
  logic [DIV_W-1:0] div_q;
  logic [5:0] phase_cnt_q;
  logic phase_run_q;
  logic [ZX_W-1:0] zx_cnt_q;
  logic mclk_rise;
  logic [DIV_W-1:0] wave_mask;
  logic [ZX_W-1:0] zx_limit;

  // ------------------------------------------------------------
  // Elaboration check
  // ------------------------------------------------------------
  if ((1 << DIV_W) < 8 * `MRP_WAVE_DIV_MIN || (1 << ZX_W) < 2 * `MRP_ZXTO_MAX)
  begin : g_bad_width
    $error("mrp_rate_gen: counters too narrow");
  end

  // Nothing advances without master clock edges, so a static clock halts all
  assign mclk_rise = i_mclk & ~mclk_prev_q;
  assign wave_mask = DIV_W'(10'h3FF >> (2'd3 - i_rate_sel));
  // Longest timeout is 4096 x 128 master clock cycles
  assign zx_limit = ZX_W'({1'b0, i_zx_timeout} + 13'h0001) * ZX_W'(`MRP_ZXTO_SCALE);

  // Edge history
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      mclk_prev_q <= 1'b0;
      zx_prev_q <= 1'b0;
    end else begin
      mclk_prev_q <= i_mclk;
      zx_prev_q <= i_zx;
    end
  end

  // Free divider on master clock edges; strobes at /4 and /128../1024
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      div_q <= '0;
      o_wave_stb <= 1'b0;
      o_energy_stb <= 1'b0;
    end else begin
      if (mclk_rise) begin
        div_q <= div_q + DIV_W'(1);
      end
      o_wave_stb <= mclk_rise && ((div_q & wave_mask) == wave_mask);
      o_energy_stb <= mclk_rise && (div_q[1:0] == 2'(`MRP_ENERGY_DIV - 1));
    end
  end

  // Phase delay counts one step per four master clock periods after a sample
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      phase_cnt_q <= '0;
      phase_run_q <= 1'b0;
      o_phase_stb <= 1'b0;
    end else begin
      o_phase_stb <= 1'b0;
      if (o_wave_stb) begin
        phase_cnt_q <= i_phase_delay;
        phase_run_q <= 1'b1;
      end else if (phase_run_q && phase_cnt_q == 6'h00) begin
        phase_run_q <= 1'b0;
        o_phase_stb <= 1'b1;
      end else if (phase_run_q && mclk_rise &&
                   div_q[1:0] == 2'(`MRP_PHASE_DIV - 1)) begin
        phase_cnt_q <= phase_cnt_q - 6'h01;
      end
    end
  end

  // Timeout counter restarts on each rising zero crossing
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      zx_cnt_q <= '0;
      o_zx_expired <= 1'b0;
    end else if (i_zx && !zx_prev_q) begin
      zx_cnt_q <= '0;
      o_zx_expired <= 1'b0;
    end else if (mclk_rise && !o_zx_expired) begin
      zx_cnt_q <= zx_cnt_q + ZX_W'(1);
      o_zx_expired <= (zx_cnt_q + ZX_W'(1)) >= zx_limit;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_energy_quarter: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_energy_stb |-> $past(div_q[1:0]) == 2'd3 && $past(mclk_rise))
    else $error("energy strobe off the four-cycle grid");

  a_zx_limit: assert property (@(posedge i_core_clk) disable iff (i_rst)
    $rose(o_zx_expired) |-> zx_cnt_q == zx_limit)
    else $error("timeout raised at wrong count");

endmodule

/* hdl/mrp_serial_port.sv */
// Serial register port of a metering device: four-wire link, command byte,
// register file, checksum, suspend and master clock rate strobes.
`timescale 1ns/1ps
`include "mrp_defs.svh"
module mrp_serial_port
  import mrp_pkg::*;
#(
  parameter int SAMPLE_W = 16,
  parameter int ENERGY_W = 24
) (
  input wire logic i_core_clk, // Core clock, 50 MHz
  input wire logic i_rst, // Reset pin or power-on, active high
  input wire logic i_sclk, // Serial clock pin
  input wire logic i_din, // Serial data in pin
  input wire logic i_cs_n, // Select pin, active low
  input wire logic i_master_clock_input, // Master clock pin
  input wire logic i_zero_cross, // Zero-crossing level pin
  input wire logic [SAMPLE_W-1:0] i_adc_sample, // Converter sample
  input wire logic [SAMPLE_W-1:0] i_power, // Instant active power, signed
  output logic o_dout, // Serial data out
  output logic o_dout_oe, // Serial data out enable
  output logic [SAMPLE_W-1:0] o_sample, // Converter sample after halt gate
  output logic o_wave_stb, // Waveform sample strobe
  output logic o_phase_stb, // Phase corrected sample strobe
  output logic o_zx_expired // Zero-crossing timeout flag
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  localparam int SH_W = 24;

  logic [4:0] pins_s;
  logic cs_n_s;
  logic sclk_s;
  logic din_s;
  logic sclk_prev_q;
  logic cs_prev_q;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  mrp_state_t st_q;
  logic [4:0] bits_q;
  logic [6:0] cmd_sh_q;
  logic [5:0] addr_q;
  logic [SH_W-1:0] shift_q;
  logic [5:0] cks_q;
  logic [15:0] mode_q;
  logic [5:0] phase_q;
  logic [11:0] zxto_q;
  logic [ENERGY_W-1:0] wave_q;
  logic [ENERGY_W-1:0] energy_q;
  logic [7:0] cmd_word;
  logic cmd_done;
  logic wr_done;
  logic rd_bit;
  logic rd_end;
  logic [SH_W-1:0] wr_word;
  logic [SH_W-1:0] rd_val;
  logic [1:0] rd_bytes;
  logic wave_stb;
  logic energy_stb;
  logic halt;

  // ------------------------------------------------------------
  // Elaboration check
  // ------------------------------------------------------------
  if (SAMPLE_W < 1 || SAMPLE_W > ENERGY_W || ENERGY_W != SH_W) begin : g_bad_width
    $error("mrp_serial_port: unsupported widths");
  end

  // ------------------------------------------------------------
  // Pin synchronisers and edges
  // ------------------------------------------------------------
  mrp_sync #(
    .WIDTH(5)
  ) u_sync (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_async({i_zero_cross, i_master_clock_input, i_din, i_sclk, i_cs_n}),
    .o_sync(pins_s)
  );

  assign cs_n_s = pins_s[0];
  assign sclk_s = pins_s[1];
  assign din_s = pins_s[2];

  // Edge history of the synchronised link pins
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      sclk_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
    end else begin
      sclk_prev_q <= sclk_s;
      cs_prev_q <= cs_n_s;
    end
  end

  // Link events are counted in serial clock edges only, never master clock
  assign sclk_rise = sclk_s & ~sclk_prev_q & ~cs_n_s;
  assign sclk_fall = ~sclk_s & sclk_prev_q & ~cs_n_s;
  assign cs_fall = ~cs_n_s & cs_prev_q;

  // ------------------------------------------------------------
  // Command decode and transfer events
  // ------------------------------------------------------------
  assign cmd_word = {cmd_sh_q, din_s};
  assign cmd_done = (st_q == MRP_ST_CMD) && sclk_fall && (bits_q == 5'd1);
  assign wr_done = (st_q == MRP_ST_WRITE) && sclk_fall && (bits_q == 5'd1);
  assign rd_bit = (st_q == MRP_ST_READ) && sclk_rise && (bits_q != 5'd0);
  assign rd_end = (st_q == MRP_ST_READ) && sclk_fall && (bits_q == 5'd0);
  assign wr_word = {shift_q[SH_W-2:0], din_s};
  assign halt = mode_q[`MRP_MODE_HALT_BIT];

  // Register widths in bytes; unmapped addresses move one byte of zeros
  always_comb begin
    rd_bytes = 2'd1;
    rd_val = '0;
    unique case (cmd_word[`MRP_CMD_ADDR_MSB:0])
      `MRP_ADDR_WAVE: begin
        rd_bytes = 2'd3;
        rd_val = wave_q;
      end
      `MRP_ADDR_ENERGY: begin
        rd_bytes = 2'd3;
        rd_val = energy_q;
      end
      `MRP_ADDR_MODE: begin
        rd_bytes = 2'd2;
        rd_val = {8'h00, mode_q};
      end
      `MRP_ADDR_PHASE: rd_val = {18'h00000, phase_q};
      `MRP_ADDR_ZXTO: begin
        rd_bytes = 2'd2;
        rd_val = {12'h000, zxto_q};
      end
      `MRP_ADDR_CKSUM: rd_val = {18'h00000, cks_q};
      default: rd_val = '0;
    endcase
  end

  // ------------------------------------------------------------
  // Serial engine
  // ------------------------------------------------------------
  // Select high always lands in command mode with the output floated, so a
  // later falling edge restarts cleanly. With select tied low only a complete
  // transfer or reset returns here.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      st_q <= MRP_ST_CMD;
      bits_q <= 5'(`MRP_CMD_BITS);
      cmd_sh_q <= '0;
      addr_q <= '0;
      shift_q <= '0;
      o_dout <= 1'b0;
      o_dout_oe <= 1'b0;
    end else if (cs_n_s || cs_fall) begin
      st_q <= MRP_ST_CMD;
      bits_q <= 5'(`MRP_CMD_BITS);
      o_dout_oe <= 1'b0;
    end else begin
      unique case (st_q)
        MRP_ST_CMD: begin
          if (sclk_fall) begin
            cmd_sh_q <= cmd_word[6:0];
            bits_q <= bits_q - 5'd1;
          end
          if (cmd_done) begin
            addr_q <= cmd_word[`MRP_CMD_ADDR_MSB:0];
            bits_q <= {rd_bytes, 3'b000};
            if (cmd_word[`MRP_CMD_WRITE_BIT]) begin
              st_q <= MRP_ST_WRITE;
              shift_q <= '0;
            end else begin
              st_q <= MRP_ST_READ;
              // Whole register captured at once, left aligned for MSB first
              shift_q <= rd_val << (5'd8 * (5'd3 - {3'b000, rd_bytes}));
            end
          end
        end
        MRP_ST_WRITE: begin
          if (sclk_fall) begin
            shift_q <= wr_word;
            bits_q <= bits_q - 5'd1;
          end
          if (wr_done) begin
            st_q <= MRP_ST_CMD;
            bits_q <= 5'(`MRP_CMD_BITS);
          end
        end
        MRP_ST_READ: begin
          if (rd_bit) begin
            o_dout <= shift_q[SH_W-1];
            o_dout_oe <= 1'b1;
            shift_q <= {shift_q[SH_W-2:0], 1'b0};
            bits_q <= bits_q - 5'd1;
          end
          // Output floats on the falling edge after the last bit
          if (rd_end) begin
            st_q <= MRP_ST_CMD;
            bits_q <= 5'(`MRP_CMD_BITS);
            o_dout_oe <= 1'b0;
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Checksum of the read in progress
  // ------------------------------------------------------------
  // Cleared as the read command completes, after the shadow copy is taken,
  // so reading the checksum returns the old value and sums its own bits
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      cks_q <= '0;
    end else if (cmd_done && !cmd_word[`MRP_CMD_WRITE_BIT] && !cs_n_s) begin
      cks_q <= '0;
    end else if (rd_bit && !cs_fall) begin
      cks_q <= cks_q + {5'h00, shift_q[SH_W-1]};
    end
  end

  // ------------------------------------------------------------
  // Writable registers
  // ------------------------------------------------------------
  // Data is right justified: unused upper bits of the first byte are dropped.
  // Commit happens only when the last bit lands, so an aborted write changes
  // nothing; that is stricter than byte-wise commit but never half-updates.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      mode_q <= `MRP_MODE_RESET;
      phase_q <= `MRP_PHASE_RESET;
      zxto_q <= `MRP_ZXTO_RESET;
    end else if (wr_done && !cs_fall) begin
      unique case (addr_q)
        `MRP_ADDR_MODE: mode_q <= wr_word[15:0];
        `MRP_ADDR_PHASE: phase_q <= wr_word[5:0];
        `MRP_ADDR_ZXTO: zxto_q <= wr_word[11:0];
        default: mode_q <= mode_q;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Master clock strobes
  // ------------------------------------------------------------
  mrp_rate_gen #(
    .DIV_W(10),
    .ZX_W(20)
  ) u_rate (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_mclk(pins_s[3]),
    .i_zx(pins_s[4]),
    .i_rate_sel(mode_q[`MRP_MODE_RATE_LSB+1:`MRP_MODE_RATE_LSB]),
    .i_phase_delay(phase_q),
    .i_zx_timeout(zxto_q),
    .o_wave_stb(wave_stb),
    .o_energy_stb(energy_stb),
    .o_phase_stb(o_phase_stb),
    .o_zx_expired(o_zx_expired)
  );

  // ------------------------------------------------------------
  // Sample capture and energy accumulation
  // ------------------------------------------------------------
  // Halt gates the converter data itself; the strobes keep running so
  // software can still read consistent zeros
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      wave_q <= '0;
      o_sample <= '0;
      o_wave_stb <= 1'b0;
    end else begin
      o_wave_stb <= wave_stb;
      if (wave_stb) begin
        o_sample <= halt ? '0 : i_adc_sample;
        wave_q <= halt ? '0 : ENERGY_W'(signed'(i_adc_sample));
      end
    end
  end

  // Active energy integrates the power input every fourth master clock edge
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      energy_q <= '0;
    end else if (energy_stb) begin
      energy_q <= energy_q + ENERGY_W'(signed'(i_power));
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_cs_fall_cmd: assert property (@(posedge i_core_clk) disable iff (i_rst)
    cs_fall |=> st_q == MRP_ST_CMD && bits_q == 5'd8)
    else $error("select fall did not restart command mode");

  a_cs_high_float: assert property (@(posedge i_core_clk) disable iff (i_rst)
    cs_n_s |=> !o_dout_oe && st_q == MRP_ST_CMD)
    else $error("output driven while select high");

  a_cmd_write_dir: assert property (@(posedge i_core_clk) disable iff (i_rst)
    cmd_done && cmd_word[7] && !cs_n_s |=> st_q == MRP_ST_WRITE)
    else $error("write command not decoded");

  a_cmd_addr_take: assert property (@(posedge i_core_clk) disable iff (i_rst)
    cmd_done && !cs_n_s |=> addr_q == $past(cmd_word[5:0]))
    else $error("address not taken from command");

  a_read_cks_clear: assert property (@(posedge i_core_clk) disable iff (i_rst)
    cmd_done && !cmd_word[7] && !cs_n_s |=> st_q == MRP_ST_READ && cks_q == 6'h00)
    else $error("checksum not cleared at read start");

  a_rd_bit_out: assert property (@(posedge i_core_clk) disable iff (i_rst)
    rd_bit && !cs_fall |=> o_dout == $past(shift_q[SH_W-1]) && o_dout_oe)
    else $error("read bit not presented");

  a_cks_adds_bit: assert property (@(posedge i_core_clk) disable iff (i_rst)
    rd_bit && !cs_fall |=> cks_q == 6'($past(cks_q) + {5'h00, $past(shift_q[SH_W-1])}))
    else $error("checksum did not count shifted bit");

  a_rd_end_cmd: assert property (@(posedge i_core_clk) disable iff (i_rst)
    rd_end && !cs_fall |=> st_q == MRP_ST_CMD && !o_dout_oe ##1 bits_q == 5'd8)
    else $error("read did not return to command mode");

  a_din_fall_only: assert property (@(posedge i_core_clk) disable iff (i_rst)
    st_q == MRP_ST_WRITE && !sclk_fall && !cs_n_s && !cs_fall |=> $stable(shift_q))
    else $error("data moved without falling serial clock");

  a_mode_write: assert property (@(posedge i_core_clk) disable iff (i_rst)
    wr_done && !cs_fall && addr_q == `MRP_ADDR_MODE |=> mode_q == $past(wr_word[15:0]))
    else $error("mode write not right justified");

  a_halt_zero: assert property (@(posedge i_core_clk) disable iff (i_rst)
    wave_stb && halt |=> o_sample == '0 && wave_q == '0)
    else $error("sample passed while halted");

endmodule

/* test/mrp_host_model.sv */
// Serial bus master model that opens, runs and closes register accesses
`timescale 1ns/1ps
module mrp_host_model #(
  parameter int HALF = 6
) (
  input wire logic i_core_clk, // Core clock, paces the link
  input wire logic i_dout, // Device serial output
  input wire logic i_dout_oe, // Device output enable
  output logic o_sclk, // Serial clock, idle high
  output logic o_din, // Serial data to device
  output logic o_cs_n // Select, active low
);
  // ------------------------------------------------------------
  // Link idle levels
  // ------------------------------------------------------------
  initial begin
    o_sclk = 1'b1;
    o_din = 1'b0;
    o_cs_n = 1'b1;
  end

  task automatic gap(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask

  // Command byte then data bits; select drops early only when abort is below nbits
  task automatic access(input logic [7:0] cmd, input int nbits, input logic [23:0] wd,
                        input int abort, output logic [23:0] rd);
    logic [31:0] sh;
    rd = '0;
    sh = {cmd, wd << (24 - nbits)};
    @(posedge i_core_clk);
    o_cs_n <= 1'b0;
    gap(HALF);
    for (int i = 0; i < 8 + nbits; i++) begin
      if (i - 8 == abort) break;
      o_din <= sh[31 - i];
      gap(HALF);
      // Half-period wait covers the output latency; an idle driver shows up as unknown
      @(negedge i_core_clk);
      if (i >= 8) rd = {rd[22:0], i_dout_oe ? i_dout : 1'bx};
      @(posedge i_core_clk);
      o_sclk <= 1'b0;
      gap(HALF);
      o_sclk <= 1'b1;
    end
    gap(HALF);
    o_din <= ~o_din; // Released line must not keep the last bit
    o_cs_n <= 1'b1;
    gap(HALF);
  endtask
endmodule

/* test/mrp_serial_port_bench.sv */
// Self-checking testbench of the metering serial register port
`timescale 1ns/1ps
module mrp_serial_port_bench;
  typedef struct {logic [7:0] cmd; int nbits; logic [23:0] wd; logic [23:0] exp;} mrp_row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] mdiv = 2'h0;
  logic mclk_run = 1'b1;
  logic zx = 1'b0;
  logic watch_phase = 1'b0;
  logic sclk, din, cs_n, dout, dout_oe, wave_stb, phase_stb, zx_exp;
  logic [15:0] adc = 16'h1234;
  logic [15:0] smp;
  logic [23:0] rd;
  int n_mismatch = 0;
  int n_compared = 0;
  int gap;
  // Reads are compared, writes only feed later reads
  mrp_row_t rows [11] = '{'{8'h10, 8, 24'h0, 24'h00000D}, '{8'h11, 16, 24'h0, 24'h000FFF},
    '{8'h3E, 8, 24'h0, 24'h00000C}, '{8'h3E, 8, 24'h0, 24'h000002},
    '{8'h90, 8, 24'h2A, 24'h0}, '{8'h10, 8, 24'h0, 24'h00002A},
    '{8'h91, 16, 24'hF123, 24'h0}, '{8'h11, 16, 24'h0, 24'h000123},
    '{8'h20, 8, 24'h0, 24'h000000}, '{8'h3E, 8, 24'h0, 24'h000000},
    '{8'h01, 24, 24'h0, 24'h001234}};

  // ------------------------------------------------------------
  // Clocks, design and host
  // ------------------------------------------------------------
  always #10 clk = ~clk;
  // Master clock at a quarter of the core rate, so strobe gaps are exact
  // Held still on demand to show that a static master clock halts the strobes
  always @(posedge clk) if (mclk_run) mdiv <= mdiv + 2'h1;

  mrp_serial_port mrp_serial_port_inst (.i_core_clk(clk), .i_rst(rst), .i_sclk(sclk),
    .i_din(din), .i_cs_n(cs_n), .i_master_clock_input(mdiv[1]), .i_zero_cross(zx),
    .i_adc_sample(adc), .i_power(16'h0010), .o_dout(dout), .o_dout_oe(dout_oe),
    .o_sample(smp), .o_wave_stb(wave_stb), .o_phase_stb(phase_stb), .o_zx_expired(zx_exp));
  mrp_host_model mrp_host_model_inst (.i_core_clk(clk), .i_dout(dout), .i_dout_oe(dout_oe),
    .o_sclk(sclk), .o_din(din), .o_cs_n(cs_n));

  task automatic check(input string nm, input logic [23:0] e, input logic [23:0] s);
    n_compared++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Cycles up to the next sample strobe, bounded
  task automatic wait_wave(output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while ((watch_phase ? phase_stb : wave_stb) !== 1'b1 && n < 5000);
    if (n >= 5000) begin
      check("strobe seen", 24'h1, 24'h0);
      final_report();
    end
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(negedge clk);
    check("idle oe", 24'h0, {23'h0, dout_oe});
    foreach (rows[k]) begin
      mrp_host_model_inst.access(rows[k].cmd, rows[k].nbits, rows[k].wd, 99, rd);
      if (!rows[k].cmd[7]) check("read data", rows[k].exp, rd);
      $display("row %0d done", k);
    end
    // Aborted read floats the output, aborted write commits nothing
    mrp_host_model_inst.access(8'h11, 16, 24'h0, 3, rd);
    @(negedge clk);
    check("oe after abort", 24'h0, {23'h0, dout_oe});
    mrp_host_model_inst.access(8'h90, 8, 24'h15, 4, rd);
    mrp_host_model_inst.access(8'h10, 8, 24'h0, 99, rd);
    check("phase after abort", 24'h2A, rd);
    $display("abort test done");
    for (int sel = 0; sel < 4; sel++) begin
      mrp_host_model_inst.access(8'h89, 16, 24'(sel << 11), 99, rd);
      wait_wave(gap);
      wait_wave(gap);
      check("wave gap", 24'((128 << sel) * 4), 24'(gap));
    end
    $display("rate test done");
    mrp_host_model_inst.access(8'h89, 16, 24'h0010, 99, rd);
    wait_wave(gap);
    wait_wave(gap);
    repeat (3) @(negedge clk);
    check("halted sample", 24'h0, {8'h0, smp});
    // Static master clock: no strobes, yet the serial port still answers
    @(posedge clk);
    mclk_run <= 1'b0;
    gap = 0;
    repeat (1200) begin
      @(negedge clk);
      if (wave_stb === 1'b1) gap++;
    end
    check("strobes while static", 24'h0, 24'(gap));
    mrp_host_model_inst.access(8'h89, 16, 24'h0000, 99, rd);
    mrp_host_model_inst.access(8'h09, 16, 24'h0, 99, rd);
    check("mode read while static", 24'h000000, rd);
    @(posedge clk);
    mclk_run <= 1'b1;
    wait_wave(gap);
    wait_wave(gap);
    repeat (3) @(negedge clk);
    check("resumed sample", 24'h001234, {8'h0, smp});
    $display("halt test done");
    // Phase strobe trails the sample strobe by four master clocks per step
    mrp_host_model_inst.access(8'h90, 8, 24'h08, 99, rd);
    wait_wave(gap);
    watch_phase = 1'b1;
    wait_wave(gap);
    watch_phase = 1'b0;
    check("phase delay", 24'(8 * 4 * 4), 24'(gap));
    $display("phase test done");
    // Timeout restarts on a crossing rise, expires after (n+1) x 128 master clocks
    @(posedge clk);
    zx <= 1'b1;
    mrp_host_model_inst.access(8'h91, 16, 24'h0001, 99, rd);
    repeat (600) @(negedge clk);
    check("timeout early", 24'h0, {23'h0, zx_exp});
    repeat (150) @(negedge clk);
    check("timeout expired", 24'h1, {23'h0, zx_exp});
    $display("timeout test done");
    // Reset in mid-run restores defaults and command mode
    @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(negedge clk);
    check("timeout after reset", 24'h0, {23'h0, zx_exp});
    check("oe after reset", 24'h0, {23'h0, dout_oe});
    mrp_host_model_inst.access(8'h10, 8, 24'h0, 99, rd);
    check("phase after reset", 24'h00000D, rd);
    $display("reset test done");
    final_report();
  end
endmodule
